// ===== swe_supervisor.sv
/*
 * swe_supervisor.sv: three-wire serial 4096-bit memory with watchdog and
 * reset stretcher. Assumes all pins are asynchronous to mclk and that the
 * serial clock is far slower than mclk (several mclk per phase).
 */
`include "swe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module swe_supervisor
   import swe_pkg::*;
#(
   parameter int unsigned CYC_WDOG  = `SWE_CYC_WDOG,
   parameter int unsigned CYC_PURST = `SWE_CYC_PURST,
   parameter int unsigned CYC_TEW   = `SWE_CYC_TEW
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // serial memory pins
   input  wire logic chipSelect,
   input  wire logic serialClk,
   input  wire logic serialIn,
   output logic      serialOut,
   output logic      serialOutOe,
   input  wire logic word_width_select,
   // reset pins, open drain
   input  wire logic resetHiIn,
   output logic      resetHiOut,
   output logic      resetHiOe,
   input  wire logic resetLoNIn,
   output logic      resetLoNOut,
   output logic      resetLoNOe
);

   localparam int CW = $clog2(CYC_WDOG + 1);

   // ******************************************************
   // pin synchronisers
   // ******************************************************
   logic [5:0] syncA_ff;
   logic [5:0] syncB_ff;
   logic [3:0] prev_ff;
   logic       csS, skS, diS, hiS, loNS, wide;
   logic       csFall, csEdge, skRise;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         syncA_ff <= `SWE_SYNC_RST;
         syncB_ff <= `SWE_SYNC_RST;
         prev_ff  <= 4'h8;
      end else begin
         syncA_ff <= {word_width_select, resetLoNIn, resetHiIn, serialIn, serialClk, chipSelect};
         syncB_ff <= syncA_ff;
         prev_ff  <= {syncB_ff[4:3], syncB_ff[1:0]};
      end
   end

   assign csS    = syncB_ff[0];
   assign skS    = syncB_ff[1];
   assign diS    = syncB_ff[2];
   assign hiS    = syncB_ff[3];
   assign loNS   = syncB_ff[4];
   assign wide   = syncB_ff[5];
   assign csFall = ~csS & prev_ff[0];
   assign csEdge = csS ^ prev_ff[0];
   assign skRise = csS & skS & ~prev_ff[1];

   // ******************************************************
   // frame decoder
   // ******************************************************
   swe_state_t state_ff;
   swe_prog_t  pend_ff, kind_ff;
   logic [3:0]  cnt_ff;
   logic [1:0]  opc_ff;
   logic [8:0]  addr_ff, ptr_ff;
   logic [15:0] dat_ff, rdSh_ff, vld_ff;
   logic [4:0]  base_ff;
   logic [7:0]  buf_ff [16];
   logic [7:0]  mem_ff [512];
   logic        wrEn_ff, rdAct_ff, doBit_ff, stat_ff, busy_ff;
   logic [CW-1:0] progCnt_ff;
   logic [8:0]  nxtAddr, nxtPtr;
   logic [15:0] nxtDat;
   logic [1:0]  topBits;
   logic [3:0]  unitEnd, addrEnd;
   logic        rdStart, unlockEv, commit;

   // read unit left aligned so the output always takes bit 15
   function automatic logic [15:0] rdUnit(input logic [8:0] a, input logic w);
      rdUnit = w ? {mem_ff[{a[7:0], 1'b0}], mem_ff[{a[7:0], 1'b1}]} : {mem_ff[a], 8'h00};
   endfunction

   assign nxtAddr  = {addr_ff[7:0], diS};
   assign nxtDat   = {dat_ff[14:0], diS};
   assign topBits  = wide ? nxtAddr[7:6] : nxtAddr[8:7];
   assign unitEnd  = wide ? 4'hF : 4'h7;
   assign addrEnd  = wide ? 4'h7 : 4'h8;
   assign nxtPtr   = wide ? {1'b0, ptr_ff[7:0] + 8'h01} : ptr_ff + 9'h001;
   assign rdStart  = skRise && state_ff == ST_ADDR && cnt_ff == addrEnd && opc_ff == `SWE_OPC_READ;
   assign unlockEv = skRise && state_ff == ST_ADDR && cnt_ff == addrEnd && opc_ff == `SWE_OPC_EXT
                     && topBits == `SWE_EXT_UNLOCK;
   assign commit   = busy_ff && progCnt_ff == '0;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         pend_ff  <= PG_NONE;
         cnt_ff   <= 4'h0;
         opc_ff   <= 2'h0;
         addr_ff  <= 9'h000;
         ptr_ff   <= 9'h000;
         dat_ff   <= 16'h0000;
         rdSh_ff  <= 16'h0000;
         vld_ff   <= 16'h0000;
         base_ff  <= 5'h00;
         wrEn_ff  <= 1'b0;
         rdAct_ff <= 1'b0;
         doBit_ff <= 1'b0;
         for (int i = 0; i < 16; i++) buf_ff[i] <= `SWE_ERASED;
      end else if (csFall || !csS) begin
         state_ff <= ST_IDLE;
         pend_ff  <= PG_NONE;
         rdAct_ff <= 1'b0;
      end else if (skRise) begin
         unique case (state_ff)
            ST_IDLE: begin
               // zeros before the start bit are skipped; frames wait while busy
               if (diS && !busy_ff) begin
                  state_ff <= ST_OPC;
                  cnt_ff   <= 4'h0;
               end
            end
            ST_OPC: begin
               opc_ff <= {opc_ff[0], diS};
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h1) begin
                  state_ff <= ST_ADDR;
                  cnt_ff   <= 4'h0;
               end
            end
            ST_ADDR: begin
               addr_ff <= nxtAddr;
               cnt_ff  <= cnt_ff + 4'h1;
               if (cnt_ff == addrEnd) begin
                  cnt_ff   <= 4'h0;
                  state_ff <= ST_HOLD;
                  vld_ff   <= 16'h0000;
                  base_ff  <= wide ? nxtAddr[7:3] : nxtAddr[8:4];
                  ptr_ff   <= wide ? {1'b0, nxtAddr[7:0]} : nxtAddr;
                  unique case (opc_ff)
                     `SWE_OPC_READ: begin
                        state_ff <= ST_READ;
                        rdAct_ff <= 1'b1;
                        doBit_ff <= 1'b0;
                        rdSh_ff  <= rdUnit(nxtAddr, wide);
                     end
                     `SWE_OPC_WRITE: begin
                        if (wrEn_ff) state_ff <= ST_DATA;
                     end
                     `SWE_OPC_ERASE: begin
                        // erase reuses the page path with an all-ones buffer
                        if (wrEn_ff) begin
                           pend_ff <= PG_PAGE;
                           vld_ff  <= wide ? 16'h0003 << {nxtAddr[2:0], 1'b0} : 16'h0001 << nxtAddr[3:0];
                           for (int i = 0; i < 16; i++) buf_ff[i] <= `SWE_ERASED;
                        end
                     end
                     `SWE_OPC_EXT: begin
                        unique case (topBits)
                           `SWE_EXT_UNLOCK: wrEn_ff <= 1'b1;
                           `SWE_EXT_LOCK:   wrEn_ff <= 1'b0;
                           `SWE_EXT_CLRALL: if (wrEn_ff) pend_ff <= PG_CLR;
                           `SWE_EXT_FILL: begin
                              ptr_ff <= 9'h000;
                              if (wrEn_ff) state_ff <= ST_DATA;
                           end
                        endcase
                     end
                  endcase
               end
            end
            ST_DATA: begin
               dat_ff <= nxtDat;
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == unitEnd) begin
                  cnt_ff <= 4'h0;
                  if (wide) begin
                     buf_ff[{ptr_ff[2:0], 1'b0}] <= nxtDat[15:8];
                     buf_ff[{ptr_ff[2:0], 1'b1}] <= nxtDat[7:0];
                     vld_ff <= vld_ff | (16'h0003 << {ptr_ff[2:0], 1'b0});
                     ptr_ff <= {ptr_ff[8:3], ptr_ff[2:0] + 3'h1};
                  end else begin
                     buf_ff[ptr_ff[3:0]] <= nxtDat[7:0];
                     vld_ff <= vld_ff | (16'h0001 << ptr_ff[3:0]);
                     ptr_ff <= {ptr_ff[8:4], ptr_ff[3:0] + 4'h1};
                  end
                  if (opc_ff == `SWE_OPC_EXT) begin
                     pend_ff  <= PG_FILL;
                     state_ff <= ST_HOLD;
                  end else begin
                     pend_ff <= PG_PAGE;
                  end
               end
            end
            ST_READ: begin
               doBit_ff <= rdSh_ff[15];
               cnt_ff   <= cnt_ff + 4'h1;
               rdSh_ff  <= {rdSh_ff[14:0], 1'b0};
               if (cnt_ff == unitEnd) begin
                  cnt_ff  <= 4'h0;
                  ptr_ff  <= nxtPtr;
                  rdSh_ff <= rdUnit(nxtPtr, wide);
               end
            end
            ST_HOLD: begin
            end
         endcase
      end
   end

   // ******************************************************
   // self-timed programming and status
   // ******************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_ff    <= 1'b0;
         stat_ff    <= 1'b0;
         kind_ff    <= PG_NONE;
         progCnt_ff <= '0;
      end else if (csFall && pend_ff != PG_NONE && !busy_ff) begin
         busy_ff    <= 1'b1;
         stat_ff    <= 1'b1;
         kind_ff    <= pend_ff;
         progCnt_ff <= CW'(CYC_TEW - 1);
      end else begin
         if (commit) busy_ff <= 1'b0;
         else if (busy_ff) progCnt_ff <= progCnt_ff - 1'b1;
         // a start bit, even a dummy one, drops the ready indication
         if (skRise && state_ff == ST_IDLE && diS && !busy_ff) stat_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 512; i++) mem_ff[i] <= `SWE_ERASED;
      end else if (commit) begin
         for (int i = 0; i < 512; i++) begin
            unique case (kind_ff)
               PG_CLR:  mem_ff[i] <= `SWE_ERASED;
               PG_FILL: mem_ff[i] <= (wide && i[0]) ? buf_ff[1] : buf_ff[0];
               PG_PAGE: if (i[8:4] == base_ff && vld_ff[i[3:0]]) mem_ff[i] <= buf_ff[i[3:0]];
               PG_NONE: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         serialOutOe <= 1'b0;
         serialOut   <= 1'b0;
      end else begin
         serialOutOe <= csS && (rdAct_ff || stat_ff);
         serialOut   <= rdAct_ff ? doBit_ff : ~busy_ff;
      end
   end

   // ******************************************************
   // watchdog and reset stretcher
   // ******************************************************
   logic [CW-1:0] wdCnt_ff, resCnt_ff;
   logic [2:0]    drvHist_ff;
   logic          resAct, extHeld, drvMask, extEdge, wdExpire;

   // our own drive echoes back through the pins, so mask it a while
   assign drvMask  = resetHiOe || drvHist_ff != 3'h0;
   assign extEdge  = !drvMask && ((hiS && !prev_ff[2]) || (!loNS && prev_ff[3]));
   assign extHeld  = !drvMask && (hiS || !loNS);
   assign resAct   = resCnt_ff != '0 || extHeld;
   assign wdExpire = !resAct && wdCnt_ff == CW'(CYC_WDOG - 1);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         resCnt_ff <= CW'(CYC_PURST);
      end else if (extEdge || wdExpire) begin
         resCnt_ff <= CW'(CYC_PURST);
      end else if (resCnt_ff != '0) begin
         resCnt_ff <= resCnt_ff - 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wdCnt_ff <= '0;
      end else if (resAct || csEdge || wdExpire) begin
         wdCnt_ff <= '0;
      end else begin
         wdCnt_ff <= wdCnt_ff + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         resetHiOe   <= 1'b1;
         resetHiOut  <= 1'b1;
         resetLoNOe  <= 1'b1;
         resetLoNOut <= 1'b0;
         drvHist_ff  <= 3'h0;
      end else begin
         resetHiOe   <= resCnt_ff != '0 || wdExpire;
         resetHiOut  <= 1'b1;
         resetLoNOe  <= resCnt_ff != '0 || wdExpire;
         resetLoNOut <= 1'b0;
         drvHist_ff  <= {drvHist_ff[1:0], resetHiOe};
      end
   end

   // ******************************************************
   // assertions
   // ******************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence progStart;
      csFall && pend_ff != PG_NONE && !busy_ff;
   endsequence
   sequence progRun;
      busy_ff && stat_ff;
   endsequence

   a_out_quiet:   assert property (!csS |=> !serialOutOe) else $error("serial out driven while deselected");
   a_read_dummy:  assert property (rdStart |=> !doBit_ff ##1 (serialOutOe && !serialOut))
                     else $error("read lacks leading zero");
   a_prog_start:  assert property (progStart |=> progRun) else $error("programming did not start");
   a_locked_skip: assert property ((csFall && !wrEn_ff && !busy_ff) |=> !busy_ff)
                     else $error("locked device programmed");
   a_stay_locked: assert property ((!wrEn_ff && !unlockEv) |=> !wrEn_ff) else $error("unlocked without command");
   a_busy_status: assert property ((busy_ff && stat_ff && csS && !rdAct_ff) |=> (serialOutOe && !serialOut))
                     else $error("busy not shown low");
   a_cs_clears:   assert property (csFall |=> state_ff == ST_IDLE) else $error("decoder not cleared");
   a_sample_edge: assert property ((state_ff != $past(state_ff)) |-> $past(skRise || !csS))
                     else $error("state moved without clock edge");
   a_wdog_cs:     assert property (csEdge |=> wdCnt_ff == '0) else $error("select edge did not restart watchdog");
   a_wdog_reset:  assert property (wdExpire |=> resetHiOe ##0 resetLoNOe) else $error("expiry did not drive resets");

endmodule

`default_nettype wire

// ===== swe_cfg.svh
/*
 * swe_cfg.svh: constants of the serial memory and watchdog supervisor.
 * Assumes a 125 MHz block clock; times are held in their own unit.
 */
`ifndef SWE_CFG_SVH
`define SWE_CFG_SVH

`define SWE_CLK_KHZ      125000
`define SWE_WDOG_MS      1600
`define SWE_PURST_MS     200
`define SWE_TEW_MS       10
`define SWE_CYC_WDOG     (`SWE_WDOG_MS * `SWE_CLK_KHZ)
`define SWE_CYC_PURST    (`SWE_PURST_MS * `SWE_CLK_KHZ)
`define SWE_CYC_TEW      (`SWE_TEW_MS * `SWE_CLK_KHZ)

`define SWE_OPC_EXT      2'h0
`define SWE_OPC_WRITE    2'h1
`define SWE_OPC_READ     2'h2
`define SWE_OPC_ERASE    2'h3
`define SWE_EXT_LOCK     2'h0
`define SWE_EXT_FILL     2'h1
`define SWE_EXT_CLRALL   2'h2
`define SWE_EXT_UNLOCK   2'h3

`define SWE_ERASED       8'hFF
`define SWE_SYNC_RST     6'h10

`endif

// ===== swe_pkg.sv
/*
 * swe_pkg.sv: types of the serial memory and watchdog supervisor.
 * Assumes nothing beyond the constants header.
 */
package swe_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_HOLD} swe_state_t;
   typedef enum logic [1:0] {PG_NONE, PG_PAGE, PG_CLR, PG_FILL} swe_prog_t;
endpackage

// ===== swe_host_model.sv
/* swe_host_model.sv: host side of the three-wire serial link.
   Assumes the bench supplies mclk and calls these tasks one at a time. */
`timescale 1ns/1ps
`default_nettype none
module swe_host_model (
   // clock
   input  wire logic mclk,
   // serial pins
   output logic      chipSelect,
   output logic      serialClk,
   output logic      serialIn,
   input  wire logic serialOut,
   input  wire logic serialOutOe
);
   // ****************
   // pin tasks
   // ****************
   initial begin
      chipSelect = 1'b0;
      serialClk  = 1'b0;
      serialIn   = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // low time of 32 mclk clears 250 ns with margin
   task automatic sel(input logic v);
      tick(1);
      chipSelect <= v;
      tick(v ? 6 : 32);
   endtask
   // serial clock only runs inside bits; output read late in the high phase
   task automatic bit1(input logic b, output logic q, output logic oe);
      tick(1);
      serialIn <= b;
      tick(4);
      serialClk <= 1'b1;
      tick(7);
      // no pull on this pin: an undriven output reads as the inverse of its last value
      q  = serialOutOe ? serialOut : ~serialOut;
      oe = serialOutOe;
      serialClk <= 1'b0;
      tick(4);
   endtask
   // msb first, start bit leads the frame
   task automatic send(input int n, input logic [15:0] v, output logic q, output logic oe);
      for (int i = n - 1; i >= 0; i--) begin
         bit1(v[i], q, oe);
      end
   endtask
   task automatic recv(input int n, output logic [15:0] v);
      logic oe;
      v = '0;
      for (int i = n - 1; i >= 0; i--) begin
         bit1(1'b0, v[i], oe);
      end
   endtask
endmodule
`default_nettype wire

// ===== tb_swe_supervisor.sv
/* tb_swe_supervisor.sv: self-checking bench of the serial memory supervisor.
   Assumes shortened counts by parameter and the host model on the serial pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_swe_supervisor
   import swe_pkg::*;
;
   // ****************
   // bench setup
   // ****************
   localparam int PURST = 200;
   localparam int WDOG  = 2000;
   localparam int TEW   = 50;
   logic          mclk  = 1'b0;
   logic          rst;
   logic          wws;
   logic          extHi;
   logic          extLoN;
   logic          chipSelect;
   logic          serialClk;
   logic          serialIn;
   logic          serialOut;
   logic          serialOutOe;
   logic          resetHiOut;
   logic          resetHiOe;
   logic          resetLoNOut;
   logic          resetLoNOe;
   logic          lastQ, lastOe;
   logic [15:0]   v;
   int            aw = 9;
   int            dw = 8;
   int            bad_count = 0;
   int            total_checks = 0;
   // open-drain wires: own drive wins, else the outside pull or driver
   wire logic     resetHiIn;
   wire logic     resetLoNIn;
   assign resetHiIn  = resetHiOe ? resetHiOut : extHi;
   assign resetLoNIn = resetLoNOe ? resetLoNOut : extLoN;
   always #4 mclk = ~mclk;
   swe_supervisor #(
      .CYC_WDOG (WDOG),
      .CYC_PURST(PURST),
      .CYC_TEW  (TEW)
   ) i_swe_supervisor (
      .mclk             (mclk),
      .rst              (rst),
      .chipSelect       (chipSelect),
      .serialClk        (serialClk),
      .serialIn         (serialIn),
      .serialOut        (serialOut),
      .serialOutOe      (serialOutOe),
      .word_width_select(wws),
      .resetHiIn        (resetHiIn),
      .resetHiOut       (resetHiOut),
      .resetHiOe        (resetHiOe),
      .resetLoNIn       (resetLoNIn),
      .resetLoNOut      (resetLoNOut),
      .resetLoNOe       (resetLoNOe)
   );
   swe_host_model i_swe_host_model (
      .mclk       (mclk),
      .chipSelect (chipSelect),
      .serialClk  (serialClk),
      .serialIn   (serialIn),
      .serialOut  (serialOut),
      .serialOutOe(serialOutOe)
   );
   // ****************
   // helpers
   // ****************
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic hang(input string msg);
      bad_count++;
      $display("[ERR] %0t timeout %s", $time, msg);
      close_out();
   endtask
   task automatic waitRst(input logic want, input int bound, output int n);
      for (n = 0; n < bound && resetHiIn !== want; n++) begin
         tick(1);
      end
      if (n == bound) begin
         hang("reset pin");
      end
   endtask
   task automatic cmd(input logic [1:0] op, input logic [8:0] a);
      i_swe_host_model.sel(1'b1);
      i_swe_host_model.send(3 + aw, (16'h1 << (aw + 2)) | (16'(op) << aw) | 16'(a), lastQ, lastOe);
   endtask
   task automatic ext(input logic [1:0] sub);
      cmd(2'h0, 9'(sub) << (aw - 2));
   endtask
   task automatic dat(input logic [15:0] d);
      i_swe_host_model.send(dw, d, lastQ, lastOe);
   endtask
   // commit, poll status, then drop ready with a dummy start bit
   task automatic prog(input bit busy);
      int n;
      i_swe_host_model.sel(1'b0);
      i_swe_host_model.sel(1'b1);
      if (busy) begin
         chk({serialOutOe, serialOut}, 2'b10, "busy status");
      end
      for (n = 0; n < 400 && !(serialOutOe === 1'b1 && serialOut === 1'b1); n++) begin
         tick(1);
      end
      if (n == 400) begin
         hang("ready");
      end
      i_swe_host_model.send(1, 16'h1, lastQ, lastOe);
      chk(lastOe, 1'b0, "ready after start bit");
      i_swe_host_model.sel(1'b0);
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      cmd(2'h2, a);
      chk({lastOe, lastQ}, 2'b10, "dummy bit");
      i_swe_host_model.recv(dw, v);
      chk(v, e, "read data");
   endtask
   task automatic more(input logic [15:0] e);
      i_swe_host_model.recv(dw, v);
      chk(v, e, "next location");
   endtask
   task automatic endRd();
      i_swe_host_model.sel(1'b0);
      chk(serialOutOe, 1'b0, "output released");
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_reset();
      int n;
      tick(PURST - 20);
      chk({resetHiIn, resetLoNIn}, 2'b10, "power-up reset");
      waitRst(1'b0, 60, n);
      chk(resetLoNIn, 1'b1, "low reset released");
   endtask
   task automatic t_locked();
      cmd(2'h1, 9'h003);
      dat(16'h5A);
      i_swe_host_model.sel(1'b0);
      ext(2'h1);
      dat(16'h5A);
      i_swe_host_model.sel(1'b0);
      i_swe_host_model.sel(1'b1);
      chk(serialOutOe, 1'b0, "no status when locked");
      endRd();
      rd(9'h003, 16'hFF);
      endRd();
   endtask
   task automatic t_page();
      ext(2'h3);
      i_swe_host_model.sel(1'b0);
      cmd(2'h1, 9'h00E);
      for (int i = 1; i <= 3; i++) begin
         dat(16'(16'h11 * i));
      end
      prog(1'b1);
      rd(9'h00E, 16'h11);
      more(16'h22);
      more(16'hFF);
      endRd();
      rd(9'h000, 16'h33);
      endRd();
   endtask
   task automatic t_cont();
      cmd(2'h1, 9'h1FF);
      dat(16'hA5);
      prog(1'b0);
      rd(9'h1FF, 16'hA5);
      more(16'h33);
      endRd();
   endtask
   task automatic t_erase();
      // a read cut short by select low must leave nothing behind
      i_swe_host_model.sel(1'b1);
      i_swe_host_model.send(6, 16'h30, lastQ, lastOe);
      i_swe_host_model.sel(1'b0);
      cmd(2'h3, 9'h00E);
      prog(1'b0);
      rd(9'h00E, 16'hFF);
      more(16'h22);
      endRd();
   endtask
   task automatic t_all();
      ext(2'h1);
      dat(16'h3C);
      prog(1'b0);
      rd(9'h100, 16'h3C);
      more(16'h3C);
      endRd();
      ext(2'h2);
      prog(1'b0);
      rd(9'h1FF, 16'hFF);
      endRd();
   endtask
   task automatic t_relock();
      ext(2'h0);
      i_swe_host_model.sel(1'b0);
      cmd(2'h1, 9'h020);
      dat(16'h77);
      i_swe_host_model.sel(1'b0);
      i_swe_host_model.sel(1'b1);
      i_swe_host_model.send(3, 16'h0, lastQ, lastOe);
      rd(9'h020, 16'hFF);
      endRd();
   endtask
   task automatic t_wdog();
      int n;
      i_swe_host_model.sel(1'b1);
      tick(WDOG - 300);
      i_swe_host_model.sel(1'b0);
      tick(WDOG - 300);
      chk(resetHiIn, 1'b0, "watchdog restarted");
      waitRst(1'b1, 400, n);
      chk(resetLoNIn, 1'b0, "both resets");
      waitRst(1'b0, PURST + 50, n);
   endtask
   task automatic t_rstin();
      int n;
      // our own drive masks the pins a few cycles after release; let that run out first
      tick(4);
      extHi <= 1'b1;
      tick(3);
      extHi <= 1'b0;
      tick(10);
      chk({resetHiIn, resetLoNIn}, 2'b10, "stretched reset");
      waitRst(1'b0, PURST + 50, n);
      chk(16'(n > PURST - 30), 16'h1, "stretch length");
      tick(4);
      extLoN <= 1'b0;
      tick(PURST + 100);
      chk(resetHiIn, 1'b0, "stretch ends while held");
      // a free watchdog would expire inside this wait
      tick(WDOG);
      chk(resetHiIn, 1'b0, "watchdog held by input");
      extLoN <= 1'b1;
      waitRst(1'b0, 20, n);
   endtask
   task automatic t_word();
      wws <= 1'b1;
      rst <= 1'b1;
      tick(5);
      rst <= 1'b0;
      aw = 8;
      dw = 16;
      ext(2'h3);
      i_swe_host_model.sel(1'b0);
      cmd(2'h1, 9'h007);
      dat(16'h1234);
      dat(16'h5678);
      prog(1'b0);
      rd(9'h007, 16'h1234);
      more(16'hFFFF);
      endRd();
      rd(9'h000, 16'h5678);
      endRd();
   endtask
   initial begin
      rst    = 1'b1;
      wws    = 1'b0;
      extHi  = 1'b0;
      extLoN = 1'b1;
      tick(2);
      chk({resetHiIn, resetLoNIn, serialOutOe}, 3'b100, "in reset");
      tick(3);
      rst <= 1'b0;
      t_reset();
      t_locked();
      t_page();
      t_cont();
      t_erase();
      t_all();
      t_relock();
      t_wdog();
      t_rstin();
      t_word();
      close_out();
   end
endmodule
`default_nettype wire
